/* File: include/grfs_regs.svh */
// Purpose: constants of the gauge reset, fault and status block
// Assumes: 25 MHz core clock, 16-bit serial words
// Notes:   definitions only
`ifndef GRFS_REGS_SVH
`define GRFS_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define GRFS_CLK_PERIOD_NS  40
`define GRFS_CAL_UNIT_NS    1000
`define GRFS_CAL_UNIT_CYC   ((`GRFS_CAL_UNIT_NS + `GRFS_CLK_PERIOD_NS - 1) / `GRFS_CLK_PERIOD_NS)
`define GRFS_CAL_CNT_MAX    9'h1ff
`define GRFS_CAL_DIV_MIN    4'h4
`define GRFS_CAL_DIV_MAX    4'hf

// ---------------------------------------------------------------
// word layout
// ---------------------------------------------------------------
`define GRFS_CMD_MSB        15
`define GRFS_CMD_LSB        13
`define GRFS_EN_NULL        12
`define GRFS_EN_CAL         3
`define GRFS_EN_TGT         4
`define GRFS_HC_STEP_MSB    3
`define GRFS_HC_BLANK       4
`define GRFS_HC_PRE_MSB     12
`define GRFS_HC_PRE_LSB     5
`define GRFS_HM_GAUGE       0
`define GRFS_HM_RUN         1
`define GRFS_HM_ACC_MSB     3
`define GRFS_HM_ACC_LSB     2
`define GRFS_HM_FREE        4
`define GRFS_POS_MSB        11

// ---------------------------------------------------------------
// reset values and synchroniser slots
// ---------------------------------------------------------------
`define GRFS_STEP_DEFAULT   4'h6
`define GRFS_SY_CS          0
`define GRFS_SY_THERM       1
`define GRFS_SY_TOK         3
`define GRFS_SY_OVER        5
`define GRFS_SY_UNDER       6
`define GRFS_SY_LOW         7
`define GRFS_SY_TOG         8
`define GRFS_SY_W           9

`endif

/* File: include/grfs_pkg.sv */
// Purpose: types of the gauge reset, fault and status block
// Assumes: grfs_regs.svh holds the numbers
// Notes:   command codes sit in word bits 15:13
package grfs_pkg;
  `include "grfs_regs.svh"

  typedef enum logic [2:0] {
    CMD_ENABLE_CONFIG = 3'h0,
    CMD_HOMING_CONFIG = 3'h1,
    CMD_HOMING        = 3'h2,
    CMD_POINTER_A     = 3'h3,
    CMD_POINTER_B     = 3'h4
  } grfs_cmd_e;

  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_ARMED = 2'b01,
    CAL_MEAS  = 2'b10
  } grfs_cal_e;

  typedef struct packed {
    logic [`GRFS_SY_W-1:0] sy1;
    logic [`GRFS_SY_W-1:0] sy2;
    logic                  tog_seen;
    logic                  cs_prev;
    logic [1:0]            en;
    logic [1:0]            therm_flag;
    logic                  supply_latch;
    logic                  supply_flag;
    logic                  cal_flag;
    grfs_cal_e             cal_st;
    logic [8:0]            cal_cnt;
    logic [3:0]            cal_div;
    logic                  clk_tgt;
    logic [3:0]            step;
    logic                  blank;
    logic [7:0]            preload;
    logic [1:0]            homing;
    logic [1:0]            acc_sel;
    logic                  free_run;
    logic                  route_en;
    logic                  route_gauge;
    logic                  route_sine;
    logic [11:0]           pos;
    logic [1:0]            pos_stb;
    logic [15:0]           status;
  } grfs_core_s;

  typedef struct packed {
    logic [14:0] shreg;
    logic [15:0] word;
    logic        tog;
  } grfs_link_s;
endpackage

/* File: include/grfs_link_if.sv */
// Purpose: carries words and status between link and core domains
// Assumes: rx_word stable for a whole frame after rx_tog flips
// Notes:   tx_status frozen by the core while chip select is low
`timescale 1ns/1ps
`default_nettype none
interface grfs_link_if;
  logic [15:0] rx_word;
  logic        rx_tog;
  logic [15:0] tx_status;

  modport link (output rx_word, output rx_tog, input tx_status);
  modport core (input rx_word, input rx_tog, output tx_status);
endinterface
`default_nettype wire

/* File: logic/grfs_link.sv */
// Purpose: serial shifter on the link clock
// Assumes: data sampled on sclk rising, msb first, 16 bits per frame
// Notes:   bit counter cleared by chip select high, so a cut frame resyncs
`timescale 1ns/1ps
`default_nettype none
module grfs_link
  import grfs_pkg::*;
(
  // link pins
  input  wire logic sclk,
  input  wire logic cs_b,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  // reset
  input  wire logic rst_b,
  // core side
  grfs_link_if.link lk
);
  grfs_link_s r;
  grfs_link_s nx;
  logic [3:0] cnt_r;

  // ---------------------------------------------------------------
  // bit counter, frame ends it without a clock edge
  // ---------------------------------------------------------------
  always_ff @(posedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (cs_b) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // shift register
  // ---------------------------------------------------------------
  always_comb begin
    nx = r;
    if (!cs_b) begin
      if (cnt_r == 4'hf) begin
        nx.word = {r.shreg, si};
        nx.tog  = ~r.tog;
      end else begin
        nx.shreg = {r.shreg[13:0], si};
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  assign lk.rx_word = r.word;
  assign lk.rx_tog  = r.tog;
  assign so         = lk.tx_status[4'hf - cnt_r];
  assign so_oe      = ~cs_b;
endmodule // grfs_link
`default_nettype wire

/* File: logic/grfs_core.sv */
// Purpose: reset defaults, fault flags and bring-up control of a dual gauge driver
// Assumes: rst_b combines power-up and the reset pin; motion engine on clk
// Notes:   clk_en freezes the core domain only; the link runs on sclk
`timescale 1ns/1ps
`default_nettype none
module grfs_core
  import grfs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // sensors, asynchronous
  input  wire logic        logic_supply_low,
  input  wire logic        supply_over,
  input  wire logic        supply_under,
  input  wire logic [1:0]  thermal_over,
  input  wire logic [1:0]  temp_below_hyst,
  // motion engine, same clock
  input  wire logic [1:0]  homing_done,
  input  wire logic [1:0]  pointer_moved,
  input  wire logic [7:0]  accum_bits,
  input  wire logic        coil_sine_driven,
  // gauge control
  output logic             enable_gauge_a,
  output logic             enable_gauge_b,
  output logic [11:0]      pointer_position,
  output logic [1:0]       pointer_strobe,
  // clock calibration
  output logic [3:0]       cal_divisor,
  output logic             clock_target_select,
  // homing
  output logic [3:0]       homing_step_time,
  output logic             homing_blanking_select,
  output logic [7:0]       homing_accumulator_preload,
  output logic [1:0]       homing_active,
  output logic [1:0]       homing_accum_select,
  output logic             homing_free_run,
  output logic             homing_route_en,
  output logic             homing_route_gauge,
  output logic             homing_route_sine,
  // status
  output logic             thermal_flag_gauge_a,
  output logic             thermal_flag_gauge_b,
  output logic             supply_range_flag,
  output logic             calibration_range_flag
);
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [8:0] CAL_UNIT = 9'(`GRFS_CAL_UNIT_CYC);

  function automatic grfs_core_s core_default();
    grfs_core_s d;
    d              = '0;
    d.cal_st       = CAL_IDLE;
    d.step         = `GRFS_STEP_DEFAULT;
    d.supply_latch = 1'b1;
    d.supply_flag  = 1'b1;
    d.cs_prev      = 1'b1;
    return d;
  endfunction

  localparam grfs_core_s ST_RESET = core_default();

  // ---------------------------------------------------------------
  // link
  // ---------------------------------------------------------------
  grfs_link_if lk ();

  grfs_link u_link (
    .sclk  (sclk),
    .cs_b  (cs_b),
    .si    (si),
    .so    (so),
    .so_oe (so_oe),
    .rst_b (rst_b),
    .lk    (lk.link)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  grfs_core_s r;
  grfs_core_s nx;
  logic [`GRFS_SY_W-1:0] async_in;

  assign async_in = {lk.rx_tog, logic_supply_low, supply_under, supply_over,
                     temp_below_hyst, thermal_over, cs_b};

  always_comb begin
    logic        word_new;
    logic        cs_now;
    logic [1:0]  therm_now;
    logic [1:0]  tok_now;
    logic        bad_supply;
    logic [15:0] w;
    logic [12:0] d;
    logic        g;
    logic [3:0]  div;
    word_new   = 1'b0;
    cs_now     = 1'b1;
    therm_now  = 2'b00;
    tok_now    = 2'b00;
    bad_supply = 1'b0;
    w          = 16'h0000;
    d          = 13'h0000;
    g          = 1'b0;
    div        = 4'h0;
    nx         = r;
    nx.sy1     = async_in;
    nx.sy2     = r.sy1;
    if (r.sy2[`GRFS_SY_LOW]) begin
      // logic supply low holds the block in defaults until it recovers
      nx     = ST_RESET;
      nx.sy1 = async_in;
      nx.sy2 = r.sy1;
      nx.tog_seen = r.sy2[`GRFS_SY_TOG];
    end else begin
      word_new    = r.sy2[`GRFS_SY_TOG] ^ r.tog_seen;
      cs_now      = r.sy2[`GRFS_SY_CS];
      therm_now   = r.sy2[`GRFS_SY_THERM +: 2];
      tok_now     = r.sy2[`GRFS_SY_TOK +: 2];
      bad_supply  = r.sy2[`GRFS_SY_OVER] | r.sy2[`GRFS_SY_UNDER];
      w           = lk.rx_word;
      d           = w[12:0];
      nx.tog_seen = r.sy2[`GRFS_SY_TOG];
      nx.cs_prev  = cs_now;
      nx.pos_stb  = 2'b00;

      // -------------------------------------------------------------
      // homing ends by stall detect unless free running
      // -------------------------------------------------------------
      for (int i = 0; i < 2; i++) begin
        if (homing_done[i] && !r.free_run) begin
          nx.homing[i] = 1'b0;
        end
      end

      // -------------------------------------------------------------
      // command decode
      // -------------------------------------------------------------
      if (word_new) begin
        nx.supply_latch = 1'b0;
        unique case (w[`GRFS_CMD_MSB:`GRFS_CMD_LSB])
          CMD_ENABLE_CONFIG: begin
            if (!d[`GRFS_EN_NULL]) begin
              for (int i = 0; i < 2; i++) begin
                if (!r.homing[i]) begin
                  nx.en[i] = d[i];
                  if (d[i] && !r.en[i] && tok_now[i] && !therm_now[i]) begin
                    nx.therm_flag[i] = 1'b0;
                  end
                end
              end
              nx.clk_tgt = d[`GRFS_EN_TGT];
              if (d[`GRFS_EN_CAL]) begin
                nx.cal_st = CAL_ARMED;
              end
            end
          end
          CMD_HOMING_CONFIG: begin
            nx.step    = d[`GRFS_HC_STEP_MSB:0];
            nx.blank   = d[`GRFS_HC_BLANK];
            nx.preload = d[`GRFS_HC_PRE_MSB:`GRFS_HC_PRE_LSB];
          end
          CMD_HOMING: begin
            g = d[`GRFS_HM_GAUGE];
            if (r.homing[g]) begin
              // only stop and accumulator view are taken mid-run
              nx.homing[g] = d[`GRFS_HM_RUN];
              nx.acc_sel   = d[`GRFS_HM_ACC_MSB:`GRFS_HM_ACC_LSB];
            end else if (!r.homing[~g] && d[`GRFS_HM_RUN] && r.en[g]) begin
              nx.homing[g] = 1'b1;
              nx.acc_sel   = d[`GRFS_HM_ACC_MSB:`GRFS_HM_ACC_LSB];
              nx.free_run  = d[`GRFS_HM_FREE];
            end
          end
          CMD_POINTER_A: begin
            if (!r.homing[0]) begin
              nx.pos        = d[`GRFS_POS_MSB:0];
              nx.pos_stb[0] = 1'b1;
            end
          end
          CMD_POINTER_B: begin
            if (!r.homing[1]) begin
              nx.pos        = d[`GRFS_POS_MSB:0];
              nx.pos_stb[1] = 1'b1;
            end
          end
          default: begin
            // unused codes carry status back and clear the supply latch only
          end
        endcase
      end

      // -------------------------------------------------------------
      // thermal shutdown, after decode so the set wins over a clear
      // -------------------------------------------------------------
      for (int i = 0; i < 2; i++) begin
        if (therm_now[i]) begin
          nx.en[i]         = 1'b0;
          nx.homing[i]     = 1'b0;
          nx.therm_flag[i] = 1'b1;
        end
        if (!nx.en[i]) begin
          nx.homing[i] = 1'b0;
        end
      end

      // -------------------------------------------------------------
      // supply range, independent of the gauge enables
      // -------------------------------------------------------------
      nx.supply_flag = nx.supply_latch | bad_supply;

      // -------------------------------------------------------------
      // clock calibration against the chip select pulse
      // -------------------------------------------------------------
      unique case (r.cal_st)
        CAL_IDLE: begin
        end
        CAL_ARMED: begin
          if (r.cs_prev && !cs_now) begin
            nx.cal_st  = CAL_MEAS;
            nx.cal_cnt = 9'h000;
          end
        end
        CAL_MEAS: begin
          if (cs_now) begin
            // a pulse outside the window keeps the old divisor
            div = 4'((r.cal_cnt / CAL_UNIT) > 9'h00f ? 9'h01f : (r.cal_cnt / CAL_UNIT));
            if ((r.cal_cnt / CAL_UNIT) > 9'h00f || div < `GRFS_CAL_DIV_MIN) begin
              nx.cal_flag = 1'b1;
            end else begin
              nx.cal_flag = 1'b0;
              nx.cal_div  = (!r.clk_tgt && div != `GRFS_CAL_DIV_MAX) ? div + 4'h1 : div;
            end
            nx.cal_st = CAL_IDLE;
          end else if (r.cal_cnt != `GRFS_CAL_CNT_MAX) begin
            nx.cal_cnt = r.cal_cnt + 9'h001;
          end
        end
        default: begin
          nx.cal_st = CAL_IDLE;
        end
      endcase

      // -------------------------------------------------------------
      // homing sense routing
      // -------------------------------------------------------------
      nx.route_en    = |nx.homing;
      nx.route_gauge = nx.homing[1];
      nx.route_sine  = ~coil_sine_driven;

      // -------------------------------------------------------------
      // status word, frozen while a frame is shifting out
      // -------------------------------------------------------------
      if (cs_now) begin
        nx.status = {accum_bits, nx.cal_flag, nx.supply_flag, pointer_moved,
                     nx.homing, nx.therm_flag};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= ST_RESET;
    end else if (clk_en) begin
      r <= nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign lk.tx_status                = r.status;
  assign enable_gauge_a              = r.en[0];
  assign enable_gauge_b              = r.en[1];
  assign pointer_position            = r.pos;
  assign pointer_strobe              = r.pos_stb;
  assign cal_divisor                 = r.cal_div;
  assign clock_target_select         = r.clk_tgt;
  assign homing_step_time            = r.step;
  assign homing_blanking_select      = r.blank;
  assign homing_accumulator_preload  = r.preload;
  assign homing_active               = r.homing;
  assign homing_accum_select         = r.acc_sel;
  assign homing_free_run             = r.free_run;
  assign homing_route_en             = r.route_en;
  assign homing_route_gauge          = r.route_gauge;
  assign homing_route_sine           = r.route_sine;
  assign thermal_flag_gauge_a        = r.therm_flag[0];
  assign thermal_flag_gauge_b        = r.therm_flag[1];
  assign supply_range_flag           = r.supply_flag;
  assign calibration_range_flag      = r.cal_flag;
endmodule // grfs_core
`default_nettype wire

/* File: dv/grfs_core_monitor.sv */
// Purpose: concurrent checks on the core ports
// Assumes: sensors pass a 2-flop sync before acting
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module grfs_core_monitor
  import grfs_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // sensors
  input wire logic       logic_supply_low,
  input wire logic       supply_over,
  input wire logic       supply_under,
  input wire logic [1:0] thermal_over,
  input wire logic [1:0] temp_below_hyst,
  // watched outputs
  input wire logic       enable_gauge_a,
  input wire logic       enable_gauge_b,
  input wire logic [3:0] homing_step_time,
  input wire logic [3:0] cal_divisor,
  input wire logic [1:0] homing_active,
  input wire logic       homing_route_en,
  input wire logic [1:0] pointer_strobe,
  input wire logic       thermal_flag_gauge_a,
  input wire logic       supply_range_flag,
  input wire logic       calibration_range_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  chk_reset_defaults: assert property (
    $rose(rst_b) |-> !enable_gauge_a && !enable_gauge_b && supply_range_flag
      && homing_step_time == 4'h6 && cal_divisor == 4'h0)
    else $error("defaults missing after reset");
  chk_low_supply: assert property (
    logic_supply_low [*5] |-> !enable_gauge_a && !enable_gauge_b
      && homing_step_time == 4'h6 && supply_range_flag)
    else $error("low logic supply did not restore defaults");
  chk_thermal_off: assert property (
    thermal_over[0] [*5] |-> !enable_gauge_a && thermal_flag_gauge_a)
    else $error("overheated gauge still enabled or unflagged");
  // sync latency means the cause is seen a few cycles back
  chk_thermal_hold: assert property (
    $fell(thermal_flag_gauge_a) |-> $past(temp_below_hyst[0], 3)
      || $past(logic_supply_low, 3))
    else $error("thermal flag cleared above hysteresis");
  chk_supply_over: assert property (
    supply_over [*5] |-> supply_range_flag)
    else $error("overvoltage not flagged");
  chk_supply_under: assert property (
    supply_under [*5] |-> supply_range_flag)
    else $error("undervoltage not flagged");
  chk_homing_route: assert property (
    $rose(homing_active[0]) |-> ##[0:2] homing_route_en)
    else $error("sense routing missing while homing");
  chk_homing_single: assert property (
    homing_active != 2'b11)
    else $error("both gauges homing");
  chk_pointer_locked: assert property (
    pointer_strobe[0] |-> !$past(homing_active[0]))
    else $error("pointer command taken while homing");
  chk_cal_kept: assert property (
    $rose(calibration_range_flag) |-> $stable(cal_divisor))
    else $error("divisor changed on failed calibration");
  chk_cal_range: assert property (
    $changed(cal_divisor) |-> cal_divisor >= 4'h4
      || $past(logic_supply_low, 2) || $past(logic_supply_low, 3))
    else $error("divisor loaded outside range");
endmodule // grfs_core_monitor
`default_nettype wire

/* File: dv/grfs_host.sv */
// Purpose: host master on the serial link
// Assumes: msb first, 16-bit words, link clock 32 ns, idle low
// Notes:   link clock stands still outside frames
`timescale 1ns/1ps
`default_nettype none
module grfs_host (
  // link pins
  output logic      sclk,
  output logic      cs_b,
  output logic      si,
  input  wire logic so,
  // pacing
  input  wire logic clk
);
  logic [15:0] rx_status;
  event        done_ev;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    rx_status = 16'h0000;
  end
  // -------------------------------------------------------------
  // transfers
  // -------------------------------------------------------------
  // select leads the first edge by 4 clk, spacing 6 clk after
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    cs_b = 1'b0;
    repeat (4) @(negedge clk);
    #7;
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      #16;
      rx_status[i] = so;
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
    si = ~si;
    repeat (2) @(negedge clk);
    cs_b = 1'b1;
    repeat (4) @(negedge clk);
    ->done_ev;
  endtask
  // reference pulse with the link clock stopped
  task automatic pulse(input int ns);
    @(negedge clk);
    cs_b = 1'b0;
    #(ns);
    cs_b = 1'b1;
    repeat (12) @(negedge clk);
  endtask
endmodule // grfs_host
`default_nettype wire

/* File: dv/gauge_reset_fault_status_test.sv */
// Purpose: self-checking bench of the gauge reset and fault core
// Assumes: status bits 7 cal, 6 supply, 3:2 homing, 1:0 thermal
// Notes:   status compares pass through a queue of masked notes
`timescale 1ns/1ps
`default_nettype none
module gauge_reset_fault_status_test;
  import grfs_pkg::*;
  logic        clk, rst_b, logic_supply_low, supply_over, supply_under;
  logic        sclk, cs_b, si, so, so_oe;
  logic [1:0]  thermal_over, temp_below_hyst, homing_done, pointer_strobe, homing_active;
  logic [7:0]  accum_bits, homing_accumulator_preload;
  logic        enable_gauge_a, enable_gauge_b, clock_target_select, homing_blanking_select;
  logic        homing_route_en, thermal_flag_gauge_a, thermal_flag_gauge_b;
  logic        homing_route_gauge, homing_route_sine, homing_free_run;
  logic [1:0]  homing_accum_select;
  logic        supply_range_flag, calibration_range_flag;
  logic [11:0] pointer_position;
  logic [3:0]  cal_divisor, homing_step_time;
  logic [31:0] seed, exp_e;
  logic [31:0] exp_q[$];
  int          mismatches, samples_checked;
  logic [15:0] cal_w[4] = '{16'h001b, 16'h000b, 16'h001b, 16'h001b};
  int          cal_ns[4] = '{8100, 8100, 2020, 8100};
  logic [5:0]  cal_x[4] = '{6'h28, 6'h09, 6'h39, 6'h28};
  grfs_core dut (.clk, .rst_b, .clk_en(1'b1), .sclk, .cs_b, .si, .so, .so_oe,
    .logic_supply_low, .supply_over, .supply_under, .thermal_over, .temp_below_hyst,
    .homing_done, .pointer_moved(2'b00), .accum_bits, .coil_sine_driven(1'b0),
    .enable_gauge_a, .enable_gauge_b, .pointer_position, .pointer_strobe, .cal_divisor,
    .clock_target_select, .homing_step_time, .homing_blanking_select,
    .homing_accumulator_preload, .homing_active, .homing_accum_select, .homing_free_run,
    .homing_route_en, .homing_route_gauge, .homing_route_sine, .thermal_flag_gauge_a,
    .thermal_flag_gauge_b, .supply_range_flag, .calibration_range_flag);
  grfs_host host (.sclk, .cs_b, .si, .so, .clk);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [15:0] w, input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v & m});
    host.send(w);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // status returned by each frame, oldest note first
  always @(host.done_ev) begin
    exp_e = exp_q.pop_front();
    chk(host.rx_status & exp_e[31:16], exp_e[15:0]);
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    {rst_b, logic_supply_low, supply_over, supply_under} = 4'h0;
    {thermal_over, homing_done, accum_bits} = 12'h000;
    temp_below_hyst = 2'b11;
    seed = 32'h859d0aed;
    mismatches = 0;
    samples_checked = 0;
    tick(20);
    rst_b = 1'b1;
    tick(2);
    chk({enable_gauge_b, enable_gauge_a, supply_range_flag}, 3'b001);
    chk({cal_divisor, homing_accumulator_preload, homing_step_time}, 16'h0006);
    xfer(16'h1000, 16'h00cf, 16'h0040);
    xfer(16'h1000, 16'h0040, 16'h0000);
    chk(so_oe, 1'b0);
    $display("test defaults done");
    for (int i = 1; i < 4; i++) begin
      xfer(16'(i), 16'h0, 16'h0);
      chk({enable_gauge_b, enable_gauge_a}, 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      accum_bits = seed[31:24];
      xfer({3'h1, seed[12:0]}, 16'hff00, {seed[31:24], 8'h00});
      chk({homing_accumulator_preload, homing_blanking_select, homing_step_time},
        {3'h0, seed[12:0]});
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      xfer(cal_w[i], 16'h0, 16'h0);
      host.pulse(cal_ns[i]);
      chk({clock_target_select, calibration_range_flag, cal_divisor}, cal_x[i]);
      xfer(16'h1000, 16'h0080, {8'h00, cal_x[i][4], 7'h00});
    end
    $display("test calibration done");
    thermal_over = 2'b01;
    temp_below_hyst = 2'b00;
    tick(8);
    chk({thermal_flag_gauge_b, thermal_flag_gauge_a, enable_gauge_b, enable_gauge_a},
      4'b0110);
    xfer(16'h1000, 16'h0003, 16'h0001);
    thermal_over = 2'b00;
    xfer(16'h0003, 16'h0, 16'h0);
    chk(thermal_flag_gauge_a, 1'b1);
    temp_below_hyst = 2'b11;
    xfer(16'h0002, 16'h0, 16'h0);
    xfer(16'h0003, 16'h0003, 16'h0001);
    chk({thermal_flag_gauge_a, enable_gauge_a}, 2'b01);
    $display("test thermal done");
    xfer(16'h0000, 16'h0, 16'h0);
    supply_over = 1'b1;
    tick(6);
    chk(supply_range_flag, 1'b1);
    xfer(16'h1000, 16'h0040, 16'h0040);
    supply_over = 1'b0;
    tick(6);
    chk(supply_range_flag, 1'b0);
    xfer(16'h0003, 16'h0, 16'h0);
    supply_under = 1'b1;
    tick(6);
    chk({supply_range_flag, enable_gauge_b, enable_gauge_a}, 3'b111);
    supply_under = 1'b0;
    tick(6);
    $display("test supply done");
    xfer(16'h6018, 16'h0, 16'h0);
    chk(pointer_position, 12'd24);
    xfer(16'h4002, 16'h0, 16'h0);
    chk({homing_route_en, homing_active}, 3'b101);
    chk({homing_route_sine, homing_route_gauge, homing_accum_select, homing_free_run},
      5'b10000);
    xfer(16'h4003, 16'h000c, 16'h0004);
    xfer(16'h6030, 16'h0, 16'h0);
    chk({pointer_position, 2'b00, homing_active}, {12'd24, 4'h1});
    homing_done = 2'b01;
    tick(1);
    homing_done = 2'b00;
    tick(4);
    chk(homing_active, 2'b00);
    $display("test homing done");
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(2);
    chk({cal_divisor, homing_step_time, enable_gauge_b, enable_gauge_a}, 10'h018);
    xfer(16'h0003, 16'h0040, 16'h0040);
    xfer(16'h2005, 16'h0, 16'h0);
    logic_supply_low = 1'b1;
    tick(6);
    chk({enable_gauge_b, enable_gauge_a, homing_step_time, supply_range_flag}, 7'h0d);
    logic_supply_low = 1'b0;
    tick(4);
    $display("test restart done");
    conclude();
  end
endmodule // gauge_reset_fault_status_test
bind grfs_core grfs_core_monitor mon (.clk, .rst_b, .logic_supply_low, .supply_over,
  .supply_under, .thermal_over, .temp_below_hyst, .enable_gauge_a, .enable_gauge_b,
  .homing_step_time, .cal_divisor, .homing_active, .homing_route_en, .pointer_strobe,
  .thermal_flag_gauge_a, .supply_range_flag, .calibration_range_flag);
`default_nettype wire
